// file: inc/pam_params.svh
`ifndef PAM_PARAMS_SVH
`define PAM_PARAMS_SVH

// ***************************************************************
// main codes, written as hex bytes of the decimal code number
// ***************************************************************
`define PAM_M_UV_CTRL      8'h0B
`define PAM_M_UV_MAIN      8'h0D
`define PAM_M_OVERHEAT     8'h0F
`define PAM_M_OVERLOAD     8'h10
`define PAM_M_REGEN        8'h12
`define PAM_M_ENC_COMM     8'h15
`define PAM_M_DEVIATION    8'h18
`define PAM_M_OVERSPEED    8'h1A
`define PAM_M_CMD_PULSE    8'h1B
`define PAM_M_REPLAY       8'h1C
`define PAM_M_OVERVOLT     8'h0C
`define PAM_M_DEV_OVF      8'h1D
`define PAM_M_RANGE        8'h22
`define PAM_M_EEP_PARAM    8'h24
`define PAM_M_EEP_CHECK    8'h25
`define PAM_M_OVERTRAVEL   8'h26
`define PAM_M_ABS_DOWN     8'h28
`define PAM_M_ABS_OVSPD    8'h2A
`define PAM_M_COMPULSORY   8'h57
`define PAM_M_AUTO_RECOG   8'h5F

// ***************************************************************
// sub codes and settings
// ***************************************************************
`define PAM_SUB0           4'h0
`define PAM_SUB1           4'h1
`define PAM_SUB2           4'h2
`define PAM_SEQ_IMM_MIN    3'h4

// ***************************************************************
// timing
// ***************************************************************
`define PAM_CLK_NS         5
`define PAM_TICK_NS        1000000
`define PAM_OVL_HOLD_MS    10000

`endif

// file: inc/pam_pkg.sv
package pam_pkg;

  typedef struct packed {
    logic [7:0] main;
    logic [3:0] sub;
  } pam_code_t;

  typedef struct packed {
    logic history;
    logic clearable;
    logic imm_stop;
  } pam_attr_t;

  typedef enum logic {
    PAM_RUN,
    PAM_TRIP
  } pam_state_t;

endpackage

// file: rtl/pam_attr_lookup.sv
`timescale 1ns/10ps
`default_nettype none
`include "pam_params.svh"

module pam_attr_lookup (
  input  wire pam_pkg::pam_code_t code,
  output var  pam_pkg::pam_attr_t attr
);

  // ***************************************************************
  // attribute table
  // ***************************************************************
  // unlisted codes are logged and need a power cycle
  always_comb begin
    attr = '{history: 1'b1, clearable: 1'b0, imm_stop: 1'b0};
    case (code.main)
      `PAM_M_UV_CTRL, `PAM_M_UV_MAIN: begin
        attr = '{history: 1'b0, clearable: 1'b1, imm_stop: 1'b0}; // see [R10]
      end
      `PAM_M_OVERVOLT, `PAM_M_OVERLOAD, `PAM_M_DEV_OVF, `PAM_M_RANGE,
      `PAM_M_ABS_DOWN, `PAM_M_ABS_OVSPD: begin
        attr.clearable = 1'b1;
      end
      `PAM_M_OVERHEAT, `PAM_M_REGEN: begin
        attr.imm_stop = 1'b1; // see [R9]
      end
      `PAM_M_ENC_COMM: begin
        attr = '{history: 1'b1, clearable: 1'b0, imm_stop: 1'b0}; // see [R11]
      end
      `PAM_M_DEVIATION: begin
        attr = '{history: 1'b1, clearable: 1'b1, imm_stop: 1'b1}; // see [R9]
      end
      `PAM_M_OVERSPEED: begin
        attr.clearable = 1'b1;
        attr.imm_stop  = (code.sub == `PAM_SUB0); // see [R9]
      end
      `PAM_M_CMD_PULSE: begin
        attr.clearable = 1'b1;
        attr.imm_stop  = (code.sub == `PAM_SUB0) || (code.sub == `PAM_SUB2); // see [R9]
      end
      `PAM_M_REPLAY: begin
        attr = '{history: 1'b1, clearable: 1'b1, imm_stop: 1'b1}; // see [R9]
      end
      `PAM_M_EEP_PARAM, `PAM_M_EEP_CHECK, `PAM_M_AUTO_RECOG: begin
        attr.history = 1'b0; // see [R13]
      end
      `PAM_M_OVERTRAVEL, `PAM_M_COMPULSORY: begin
        attr = '{history: 1'b0, clearable: 1'b1, imm_stop: 1'b0}; // see [R12]
      end
      default: begin
        attr = '{history: 1'b1, clearable: 1'b0, imm_stop: 1'b0};
      end
    endcase
  end

endmodule
`default_nettype wire

// file: rtl/pam_alarm_manager.sv
`timescale 1ns/10ps
`default_nettype none
`include "pam_params.svh"

// Summary of operation
// [R1] any protective event drops alarm output and latches the trip state
// [R2] while tripped the active code is shown on the panel display
// [R3] main and sub code are both kept for display and history
// [R4] overload 16.0 clear is refused until about ten seconds after it occurred
// [R5] codes 40.0 and 42.0 need an absolute encoder clear before clearing
// [R6] clear comes from the clear pin, the panel or the communication port
// [R7] host clears only with the motor stopped and conditions safe
// [R8] immediate stop only when the sequence setting is 4 to 7
// [R9] immediate stop attribute on 15.0 18.0 24.x 26.0 27.0 27.2 28.0
// [R10] undervoltage 11.0 and 13.0 are clearable and not logged
// [R11] encoder communication 21.x is logged and cannot be cleared
// [R12] compulsory alarm 87.0 is clearable and not logged
// [R13] eeprom parameter error 36.x is neither logged nor clearable
// [R14] accepted clear leaves the trip and restores alarm output
// [R15] 26.0 with 26.1 together shows 26.0 but gives no immediate stop
module pam_alarm_manager #(
  parameter int unsigned TICK_CYC    = `PAM_TICK_NS / `PAM_CLK_NS,
  parameter int unsigned OVL_HOLD_MS = `PAM_OVL_HOLD_MS
) (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               ev_valid,
  input  wire pam_pkg::pam_code_t ev_code,
  input  wire logic               ovs2_detect,
  input  wire logic               protect_active,
  input  wire logic [2:0]         sequence_at_alarm_setting,
  input  wire logic               alarm_clear_input,
  input  wire logic               clear_panel,
  input  wire logic               clear_comm,
  input  wire logic               abs_clear_done,
  output logic                    alarm_output,
  output logic                    tripped,
  output logic                    disp_on,
  output pam_pkg::pam_code_t      disp_code,
  output logic                    imm_stop,
  output logic                    hist_wr,
  output pam_pkg::pam_code_t      hist_code,
  output logic                    clear_ack,
  output logic                    clear_reject
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  pam_pkg::pam_state_t state;
  pam_pkg::pam_attr_t  ev_attr;
  pam_pkg::pam_attr_t  act_attr;
  logic                pin_q;
  logic                clear_req;
  logic                first_ev;
  logic                later_ev;
  logic                abs_cleared;
  logic                blocked;
  logic                ovl_wait;
  logic [31:0]         tick_cnt;
  logic                tick;
  logic [31:0]         ms_cnt;
  logic                is_ovl;
  logic                is_abs;
  logic                clear_ok;
  logic                imm_ok;
  logic [31:0]         trip_age;

  localparam logic [31:0] OVL_HOLD_CYC = 32'(OVL_HOLD_MS * TICK_CYC);

  pam_attr_lookup pam_attr_lookup_i (
    .code (ev_code),
    .attr (ev_attr)
  );

  // ***************************************************************
  // request decode
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= alarm_clear_input;
    end
  end

  // clear pin acts on its rising edge so a held pin cannot re-clear
  assign clear_req = (alarm_clear_input && !pin_q) || clear_panel || clear_comm; // see [R6]
  assign first_ev  = ev_valid && (state == pam_pkg::PAM_RUN);
  assign later_ev  = ev_valid && (state == pam_pkg::PAM_TRIP);
  assign is_ovl    = (disp_code.main == `PAM_M_OVERLOAD) && (disp_code.sub == `PAM_SUB0);
  assign is_abs    = ((disp_code.main == `PAM_M_ABS_DOWN) || (disp_code.main == `PAM_M_ABS_OVSPD))
                     && (disp_code.sub == `PAM_SUB0);
  // the second over-speed blocks the fast shutdown even when 26.0 wins the display
  assign imm_ok    = ev_attr.imm_stop && !ovs2_detect                        // see [R15]
                     && (sequence_at_alarm_setting >= `PAM_SEQ_IMM_MIN);     // see [R8]
  // host is trusted to clear only with the motor stopped; see [R7]
  assign clear_ok  = act_attr.clearable && !blocked && !protect_active       // see [R14]
                     && !(is_ovl && ovl_wait)                                // see [R4]
                     && !(is_abs && !abs_cleared);                           // see [R5]

  // ***************************************************************
  // overload hold timer
  // ***************************************************************
  // divider restarts at the trip so the hold is measured from the alarm itself
  always_ff @(posedge mclk) begin
    if (srst || first_ev) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYC - 1) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ms_cnt   <= 32'h0000_0000;
      ovl_wait <= 1'b0;
    end else if (first_ev) begin
      ms_cnt   <= 32'h0000_0000;
      ovl_wait <= 1'b1;
    end else if (tick && ovl_wait) begin
      ms_cnt   <= ms_cnt + 32'h0000_0001;
      ovl_wait <= (ms_cnt < OVL_HOLD_MS - 1); // see [R4]
    end
  end

  // cycles since the trip, saturating; only the checks read it, so synthesis drops it
  always_ff @(posedge mclk) begin
    if (srst || first_ev) begin
      trip_age <= 32'h0000_0000;
    end else if (!(&trip_age)) begin
      trip_age <= trip_age + 32'h0000_0001;
    end
  end

  // ***************************************************************
  // trip state and alarm output
  // ***************************************************************
  // a new event in the clearing cycle wins, so no alarm is lost
  always_ff @(posedge mclk) begin
    if (srst) begin
      state        <= pam_pkg::PAM_RUN;
      alarm_output <= 1'b1;
      tripped      <= 1'b0;
      disp_on      <= 1'b0;
    end else if (first_ev) begin
      state        <= pam_pkg::PAM_TRIP; // see [R1]
      alarm_output <= 1'b0;              // see [R1]
      tripped      <= 1'b1;
      disp_on      <= 1'b1;              // see [R2]
    end else begin
      case (state)
        pam_pkg::PAM_TRIP: begin
          if (clear_req && clear_ok && !later_ev) begin
            state        <= pam_pkg::PAM_RUN; // see [R14]
            alarm_output <= 1'b1;
            tripped      <= 1'b0;
            disp_on      <= 1'b0;
          end
        end
        default: begin
          state <= pam_pkg::PAM_RUN;
        end
      endcase
    end
  end

  // ***************************************************************
  // active code and its attributes
  // ***************************************************************
  // the first code stays on display; later ones affect clearing, history and the immediate stop
  always_ff @(posedge mclk) begin
    if (srst) begin
      disp_code <= '0;
      act_attr  <= '0;
    end else if (first_ev) begin
      disp_code <= ev_code;  // see [R3]
      act_attr  <= ev_attr;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || first_ev) begin
      blocked <= 1'b0;
    end else if (later_ev && !ev_attr.clearable) begin
      blocked <= 1'b1; // see [R14]
    end
  end

  // set has priority over the trip-entry reset of the flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      abs_cleared <= 1'b0;
    end else if (abs_clear_done) begin
      abs_cleared <= 1'b1; // see [R5]
    end else if (first_ev) begin
      abs_cleared <= 1'b0;
    end
  end

  // ***************************************************************
  // immediate stop
  // ***************************************************************
  // any non-fast-shutdown alarm during the stop drops straight to the trip
  always_ff @(posedge mclk) begin
    if (srst) begin
      imm_stop <= 1'b0;
    end else if (first_ev) begin
      imm_stop <= imm_ok; // see [R8]
    end else if (later_ev && (!ev_attr.imm_stop || ovs2_detect)) begin
      imm_stop <= 1'b0;
    end else if (!later_ev && ovs2_detect) begin
      imm_stop <= 1'b0;   // see [R15]
    end else if (clear_ack) begin
      imm_stop <= 1'b0;
    end
  end

  // ***************************************************************
  // history and clear answers
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      hist_wr   <= 1'b0;
      hist_code <= '0;
    end else begin
      hist_wr <= ev_valid && ev_attr.history; // see [R10] [R11] [R12] [R13]
      if (ev_valid) begin
        hist_code <= ev_code; // see [R3]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      clear_ack    <= 1'b0;
      clear_reject <= 1'b0;
    end else begin
      clear_ack    <= clear_req && (state == pam_pkg::PAM_TRIP) && clear_ok && !ev_valid;
      clear_reject <= clear_req && (state == pam_pkg::PAM_TRIP) && !(clear_ok && !ev_valid);
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  chk_trip_on_event: assert property (@(posedge mclk) disable iff (srst) // see [R1]
    first_ev |=> !alarm_output && tripped ##0 disp_on)
    else $error("alarm output not dropped after event");

  chk_display_code: assert property (@(posedge mclk) disable iff (srst) // see [R2]
    first_ev |=> (disp_code == $past(ev_code)) ##0 disp_on)
    else $error("display does not show the tripping code");

  chk_ovl_hold: assert property (@(posedge mclk) disable iff (srst) // see [R4]
    tripped && is_ovl && clear_req && (trip_age < OVL_HOLD_CYC) |=> clear_reject && tripped)
    else $error("overload cleared before hold time");

  chk_ovl_release: assert property (@(posedge mclk) disable iff (srst) // see [R4]
    tripped && is_ovl && clear_req && !ev_valid && !protect_active && !blocked
    && (trip_age > OVL_HOLD_CYC) |=> clear_ack && !tripped)
    else $error("overload clear refused after hold time");

  chk_abs_gate: assert property (@(posedge mclk) disable iff (srst) // see [R5]
    tripped && is_abs && !abs_cleared && !abs_clear_done && clear_req |=> tripped)
    else $error("absolute alarm cleared without encoder clear");

  chk_enc_keep: assert property (@(posedge mclk) disable iff (srst) // see [R11]
    tripped && (disp_code.main == `PAM_M_ENC_COMM) && clear_req |=> tripped ##0 clear_reject)
    else $error("encoder alarm was cleared");

  chk_eep_nolog: assert property (@(posedge mclk) disable iff (srst) // see [R13]
    ev_valid && (ev_code.main == `PAM_M_EEP_PARAM) |=> !hist_wr)
    else $error("eeprom alarm logged");

  chk_uv_nolog: assert property (@(posedge mclk) disable iff (srst) // see [R10]
    ev_valid && ((ev_code.main == `PAM_M_UV_CTRL) || (ev_code.main == `PAM_M_UV_MAIN))
    |=> !hist_wr)
    else $error("undervoltage logged");

  chk_imm_setting: assert property (@(posedge mclk) disable iff (srst) // see [R8]
    first_ev && (sequence_at_alarm_setting < `PAM_SEQ_IMM_MIN) |=> !imm_stop)
    else $error("immediate stop with low sequence setting");

  chk_ovs_pair: assert property (@(posedge mclk) disable iff (srst) // see [R15]
    first_ev && (ev_code.main == `PAM_M_OVERSPEED) && (ev_code.sub == `PAM_SUB0) && ovs2_detect
    |=> !imm_stop && (disp_code.sub == `PAM_SUB0))
    else $error("fast shutdown despite second over-speed");

  chk_clear_restore: assert property (@(posedge mclk) disable iff (srst) // see [R14]
    clear_ack |-> alarm_output && !tripped && $past(tripped))
    else $error("clear acknowledged but alarm output not restored");

  cov_trip_clear: cover property (@(posedge mclk) disable iff (srst)
    first_ev ##[1:20] clear_ack);

  cov_imm_stop: cover property (@(posedge mclk) disable iff (srst)
    first_ev ##1 imm_stop);

  cov_reject: cover property (@(posedge mclk) disable iff (srst)
    clear_reject ##[1:50] clear_ack);

endmodule
`default_nettype wire

// file: dv/pam_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ***************************************************************
// host controller: pulses the clear pin when asked, if the alarm output is low at the end of the wait
// ***************************************************************
module pam_host_model (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       alarm_output,
  input  wire logic       clr_req,
  input  wire logic [3:0] delay,
  output logic            alarm_clear_input
);
  logic [4:0] wait_cnt;
  logic [1:0] hold_cnt;

  // the wait stands for the host confirming the motor has stopped and it is safe
  always_ff @(posedge mclk) begin
    if (srst) begin
      wait_cnt <= 5'h00;
      hold_cnt <= 2'h0;
    end else if (clr_req) begin
      wait_cnt <= {1'b0, delay} + 5'h01;
    end else if (wait_cnt != 5'h00) begin
      wait_cnt <= wait_cnt - 5'h01;
      if (wait_cnt == 5'h01 && !alarm_output) begin
        hold_cnt <= 2'h2;
      end
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end
  end

  // pin is a level; only its rising edge matters, so it drops again soon
  assign alarm_clear_input = (hold_cnt != 2'h0);
endmodule
`default_nettype wire

// file: dv/protective_alarm_manager_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pam_params.svh"

module protective_alarm_manager_tb;
  typedef struct packed {
    logic [1:0]         kind;
    pam_pkg::pam_code_t code;
    logic               hist;
    logic               imm;
  } pam_note_t;

  localparam logic [1:0] K_TRIP = 2'h1;
  localparam logic [1:0] K_ACK  = 2'h2;
  localparam logic [1:0] K_REJ  = 2'h3;
  // code, then history / clearable / immediate stop / special (1 overload, 2 abs gate)
  localparam logic [16:0] TBL [17] = '{
    {`PAM_M_UV_CTRL, `PAM_SUB0, 5'h08}, {`PAM_M_UV_MAIN, `PAM_SUB0, 5'h08},
    {`PAM_M_OVERHEAT, `PAM_SUB0, 5'h14}, {`PAM_M_OVERLOAD, `PAM_SUB0, 5'h19},
    {`PAM_M_REGEN, `PAM_SUB0, 5'h14}, {`PAM_M_ENC_COMM, `PAM_SUB0, 5'h10},
    {`PAM_M_ENC_COMM, `PAM_SUB1, 5'h10}, {`PAM_M_DEVIATION, `PAM_SUB0, 5'h1C},
    {`PAM_M_DEVIATION, `PAM_SUB1, 5'h1C}, {`PAM_M_OVERSPEED, `PAM_SUB0, 5'h1C},
    {`PAM_M_CMD_PULSE, `PAM_SUB0, 5'h1C}, {`PAM_M_CMD_PULSE, `PAM_SUB2, 5'h1C},
    {`PAM_M_REPLAY, `PAM_SUB0, 5'h1C}, {`PAM_M_EEP_PARAM, `PAM_SUB2, 5'h00},
    {`PAM_M_ABS_DOWN, `PAM_SUB0, 5'h1A}, {`PAM_M_ABS_OVSPD, `PAM_SUB0, 5'h1A},
    {`PAM_M_COMPULSORY, `PAM_SUB0, 5'h08}};

  logic               mclk, srst, ev_valid, ovs2_detect, protect_active, clr_req;
  logic               clear_panel, clear_comm, abs_clear_done, alarm_clear_input;
  logic [2:0]         sequence_at_alarm_setting;
  logic [3:0]         host_delay;
  pam_pkg::pam_code_t ev_code, disp_code, hist_code;
  logic               alarm_output, tripped, disp_on, imm_stop, hist_wr;
  logic               clear_ack, clear_reject, tripped_q;
  pam_note_t          notes[$];
  int                 n_errors, check_count;

  pam_alarm_manager #(.TICK_CYC(4), .OVL_HOLD_MS(3)) pam_alarm_manager_i (
    .mclk(mclk), .srst(srst), .ev_valid(ev_valid), .ev_code(ev_code),
    .ovs2_detect(ovs2_detect), .protect_active(protect_active),
    .sequence_at_alarm_setting(sequence_at_alarm_setting),
    .alarm_clear_input(alarm_clear_input), .clear_panel(clear_panel),
    .clear_comm(clear_comm), .abs_clear_done(abs_clear_done),
    .alarm_output(alarm_output), .tripped(tripped), .disp_on(disp_on),
    .disp_code(disp_code), .imm_stop(imm_stop), .hist_wr(hist_wr),
    .hist_code(hist_code), .clear_ack(clear_ack), .clear_reject(clear_reject));

  pam_host_model pam_host_model_i (
    .mclk(mclk), .srst(srst), .alarm_output(alarm_output), .clr_req(clr_req),
    .delay(host_delay), .alarm_clear_input(alarm_clear_input));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ***************************************************************
  // checking helpers
  // ***************************************************************
  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // monitor: every result takes the oldest note
  always @(posedge mclk) begin
    pam_note_t  n;
    logic [1:0] seen;
    seen = 2'h0;
    if (!srst && tripped && !tripped_q) seen = K_TRIP;
    else if (!srst && clear_ack) seen = K_ACK;
    else if (!srst && clear_reject) seen = K_REJ;
    tripped_q <= srst ? 1'b0 : tripped;
    if (seen != 2'h0 && notes.size() == 0) begin
      chk("spurious result", 12'h000, 12'(seen));
    end else if (seen != 2'h0) begin
      n = notes.pop_front();
      chk("result kind", 12'(n.kind), 12'(seen));
      if (seen == K_TRIP) begin
        chk("alarm_output", 12'h000, 12'(alarm_output));
        chk("disp_on", 12'h001, 12'(disp_on));
        chk("disp_code", n.code, disp_code);
        chk("imm_stop", 12'(n.imm), 12'(imm_stop));
        chk("hist_wr", 12'(n.hist), 12'(hist_wr));
        if (n.hist) chk("hist_code", n.code, hist_code);
      end else if (seen == K_ACK) begin
        chk("alarm_output", 12'h001, 12'(alarm_output));
        chk("tripped", 12'h000, 12'(tripped));
        chk("disp_on", 12'h000, 12'(disp_on));
      end else begin
        chk("rejected tripped", 12'h001, 12'(tripped));
        chk("rejected alarm_output", 12'h000, 12'(alarm_output));
      end
    end
  end

  // ***************************************************************
  // drivers
  // ***************************************************************
  task automatic do_reset();
    srst <= 1'b1;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk("reset alarm_output", 12'h001, 12'(alarm_output));
  endtask

  task automatic fire(input pam_pkg::pam_code_t c, input logic o);
    @(posedge mclk);
    ev_valid <= 1'b1;
    ev_code <= c;
    ovs2_detect <= o;
    @(posedge mclk);
    ev_valid <= 1'b0;
    ovs2_detect <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic expect_clear(input logic [1:0] k, input int src);
    int i;
    if (k != 2'h0) notes.push_back('{k, 12'h000, 1'b0, 1'b0});
    @(posedge mclk);
    case (src)
      0: clr_req <= 1'b1;
      1: clear_panel <= 1'b1;
      default: clear_comm <= 1'b1;
    endcase
    @(posedge mclk);
    clr_req <= 1'b0;
    clear_panel <= 1'b0;
    clear_comm <= 1'b0;
    for (i = 0; i < 60 && notes.size() != 0; i++) @(posedge mclk);
    if (notes.size() != 0) begin
      n_errors++;
      $display("unexpected pending results expected 0 seen %0d", notes.size());
      report_and_stop();
    end
    repeat (20) @(posedge mclk);
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    int          p, i, src;
    logic [16:0] e;
    logic [2:0]  s;
    {srst, ev_valid, ovs2_detect, protect_active, clr_req} = 5'h10;
    {clear_panel, clear_comm, abs_clear_done} = 3'h0;
    ev_code = 12'h000;
    sequence_at_alarm_setting = 3'h0;
    host_delay = 4'h0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(32'hEB96FB78));
    for (p = 0; p < 3; p++) begin
      for (i = 0; i < 17; i++) begin
        e = TBL[i];
        s = (p == 0) ? 3'h3 : (p == 1) ? 3'h4 : 3'($urandom_range(7, 0));
        src = $urandom_range(2, 0);
        host_delay <= 4'($urandom_range(15, 0));
        do_reset();
        sequence_at_alarm_setting <= s;
        notes.push_back('{K_TRIP, e[16:5], e[4], e[2] && s >= `PAM_SEQ_IMM_MIN});
        fire(e[16:5], 1'b0);
        if (!e[3]) begin
          expect_clear(K_REJ, src);
        end else begin
          if (e[1:0] != 2'h0) begin
            expect_clear(K_REJ, 1);
            if (e[0]) begin
              repeat (30) @(posedge mclk);
            end else begin
              abs_clear_done <= 1'b1;
              @(posedge mclk);
              abs_clear_done <= 1'b0;
            end
          end
          expect_clear(K_ACK, src);
          expect_clear(2'h0, 1);
        end
      end
    end
    do_reset();
    sequence_at_alarm_setting <= 3'h5;
    notes.push_back('{K_TRIP, {`PAM_M_OVERSPEED, `PAM_SUB0}, 1'b1, 1'b0});
    fire({`PAM_M_OVERSPEED, `PAM_SUB0}, 1'b1);
    expect_clear(K_ACK, 2);
    do_reset();
    notes.push_back('{K_TRIP, {`PAM_M_UV_CTRL, `PAM_SUB0}, 1'b0, 1'b0});
    fire({`PAM_M_UV_CTRL, `PAM_SUB0}, 1'b0);
    protect_active <= 1'b1;
    expect_clear(K_REJ, 1);
    protect_active <= 1'b0;
    expect_clear(K_ACK, 0);
    // a later non-clearable alarm keeps the trip although the first one is clearable
    do_reset();
    notes.push_back('{K_TRIP, {`PAM_M_COMPULSORY, `PAM_SUB0}, 1'b0, 1'b0});
    fire({`PAM_M_COMPULSORY, `PAM_SUB0}, 1'b0);
    fire({`PAM_M_ENC_COMM, `PAM_SUB1}, 1'b0);
    chk("held disp_code", {`PAM_M_COMPULSORY, `PAM_SUB0}, disp_code);
    chk("later hist_code", {`PAM_M_ENC_COMM, `PAM_SUB1}, hist_code);
    expect_clear(K_REJ, 2);
    report_and_stop();
  end
endmodule
`default_nettype wire
